/* hw/omfs_ctrl.sv */
`timescale 1ns/1ps
`include "omfs_consts.svh"
module omfs_ctrl
   import omfs_pkg::*;
#(
   parameter int WIN_CYCLES = `OMFS_WIN_CYCLES,
   parameter int WDOG_CYCLES = `OMFS_WDOG_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Startup sequencing
   input wire logic cfg_loaded,
   input wire logic [1:0] cfg_mode,
   input wire logic conv_done,
   // Internal oscillator tick (asynchronous level)
   input wire logic osc_tick,
   // Failure sources
   input wire logic wdog_kick,
   input wire logic mem_check_fail,
   input wire logic reg_parity_fail,
   input wire logic sensor_open,
   input wire logic sensor_short,
   // Conditioned result
   input wire logic [15:0] result,
   input wire logic result_valid,
   // One-wire link
   input wire logic enter_command_request,
   input wire logic owi_read_req,
   output logic owi_read_ack,
   output logic owi_read_refused,
   output logic [15:0] owi_read_data,
   // Output pin control
   output omfs_pkg::omfs_pin_t output_pin_mode,
   output logic output_pin_oe_n,
   // State indications
   output logic diagnostic_state,
   output logic command_state,
   output logic normal_run_state,
   output logic owi_window_open,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Interrupt
   output logic irq
);
   import omfs_pkg::*;

   typedef enum logic [2:0] {
      OMFS_ST_CFG,
      OMFS_ST_MSTART,
      OMFS_ST_WINDOW,
      OMFS_ST_NORMAL,
      OMFS_ST_COMMAND,
      OMFS_ST_DIAG
   } omfs_state_t;

   function automatic logic mode_has_window(input omfs_mode_t m);
      return (m == OMFS_WINDOW) || (m == OMFS_OVERDRV);
   endfunction

   function automatic logic mode_drives_early(input omfs_mode_t m);
      return (m == OMFS_OVERDRV) || (m == OMFS_ANALOG);
   endfunction

   // Even parity of a control register word
   function automatic logic word_parity(input logic [15:0] v);
      return ^v;
   endfunction

   omfs_state_t state_ff, nxt_state;
   omfs_mode_t mode_ff;
   logic [22:0] win_cnt_ff;
   logic [2:0] conv_cnt_ff;
   logic [19:0] wdog_cnt_ff;
   logic [7:0] osc_gap_ff;
   logic osc_prev_ff;
   logic [`OMFS_EV_W-1:0] irq_stat_ff, irq_mask_ff, ev;
   logic [15:0] ctrl_ff;
   logic ctrl_par_ff, mask_par_ff, reg_par_err;
   logic osc_s;
   logic [6:0] async_s;
   logic wdog_fail, osc_fail, any_fail, osc_edge, win_open, cmd_take, clr_diag;

   // Pin-side and analog failure inputs enter through the synchroniser
   omfs_sync #(.W(8)) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d({osc_tick, enter_command_request, owi_read_req, mem_check_fail,
          reg_parity_fail, sensor_open, sensor_short, wdog_kick}),
      .q({osc_s, async_s})
   );

   logic cmd_req_s, rd_req_s, mem_s, par_s, open_s, short_s, kick_s;
   assign {cmd_req_s, rd_req_s, mem_s, par_s, open_s, short_s, kick_s} = async_s;

   // Mode latched once the configuration memory has been read
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= OMFS_OWI_ONLY;
      end else if (state_ff == OMFS_ST_CFG && cfg_loaded) begin
         mode_ff <= omfs_mode_t'(cfg_mode);
      end
   end

   // Watchdog
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wdog_cnt_ff <= '0;
      end else if (kick_s || state_ff == OMFS_ST_CFG) begin
         wdog_cnt_ff <= '0;
      end else if (!wdog_fail) begin
         wdog_cnt_ff <= wdog_cnt_ff + 20'h1;
      end
   end
   assign wdog_fail = (wdog_cnt_ff >= 20'(WDOG_CYCLES));

   // Oscillator monitor: edges of the synchronised tick, gap counter
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         osc_prev_ff <= 1'b0;
         osc_gap_ff <= '0;
      end else begin
         osc_prev_ff <= osc_s;
         if (osc_edge) begin
            osc_gap_ff <= '0;
         end else if (osc_gap_ff != `OMFS_OSC_GAP) begin
            osc_gap_ff <= osc_gap_ff + 8'h1;
         end
      end
   end
   assign osc_edge = osc_s && !osc_prev_ff;
   assign osc_fail = (osc_gap_ff == `OMFS_OSC_GAP);

   assign any_fail = wdog_fail || osc_fail || mem_s || par_s || reg_par_err
                     || open_s || short_s;

   // Measurement start: count conversions
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         conv_cnt_ff <= '0;
      end else if (state_ff != OMFS_ST_MSTART) begin
         conv_cnt_ff <= '0;
      end else if (conv_done) begin
         conv_cnt_ff <= conv_cnt_ff + 3'h1;
      end
   end

   // Window timer counts internal oscillator cycles
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         win_cnt_ff <= '0;
      end else if (state_ff != OMFS_ST_WINDOW) begin
         win_cnt_ff <= '0;
      end else if (osc_edge && win_open) begin
         win_cnt_ff <= win_cnt_ff + 23'h1;
      end
   end
   assign win_open = (state_ff == OMFS_ST_WINDOW) && (win_cnt_ff < 23'(WIN_CYCLES));
   assign cmd_take = win_open && cmd_req_s;
   assign clr_diag = reg_wr && reg_addr == `OMFS_REG_CTRL
                     && reg_wdata[`OMFS_CTRL_CLR_DIAG];

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         OMFS_ST_CFG: begin
            if (cfg_loaded) begin
               nxt_state = OMFS_ST_MSTART;
            end
         end
         OMFS_ST_MSTART: begin
            if (conv_done && conv_cnt_ff == `OMFS_START_CONV - 3'h1) begin
               nxt_state = mode_has_window(mode_ff) ? OMFS_ST_WINDOW : OMFS_ST_NORMAL;
            end
         end
         OMFS_ST_WINDOW: begin
            if (cmd_take) begin
               nxt_state = OMFS_ST_COMMAND;
            end else if (!win_open) begin
               nxt_state = OMFS_ST_NORMAL;
            end
         end
         OMFS_ST_NORMAL, OMFS_ST_COMMAND: begin
         end
         OMFS_ST_DIAG: begin
            if (clr_diag && !any_fail) begin
               nxt_state = OMFS_ST_CFG;
            end
         end
         default: nxt_state = OMFS_ST_CFG;
      endcase
      if (any_fail) begin
         nxt_state = OMFS_ST_DIAG;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= OMFS_ST_CFG;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Output pin control
   always_comb begin
      output_pin_mode = OMFS_PIN_FAULT_BAND;
      case (state_ff)
         OMFS_ST_CFG, OMFS_ST_DIAG: output_pin_mode = OMFS_PIN_FAULT_BAND;
         OMFS_ST_MSTART: begin
            output_pin_mode = mode_drives_early(mode_ff) ? OMFS_PIN_FAULT_BAND
                                                         : OMFS_PIN_TRISTATE;
         end
         OMFS_ST_WINDOW: begin
            // Overdrive mode drives analog during the window; master overpowers it
            output_pin_mode = (mode_ff == OMFS_OVERDRV) ? OMFS_PIN_ANALOG
                                                        : OMFS_PIN_TRISTATE;
         end
         OMFS_ST_NORMAL: begin
            output_pin_mode = (mode_ff == OMFS_OWI_ONLY) ? OMFS_PIN_TRISTATE
                                                         : OMFS_PIN_ANALOG;
         end
         OMFS_ST_COMMAND: output_pin_mode = OMFS_PIN_TRISTATE;
         default: output_pin_mode = OMFS_PIN_FAULT_BAND;
      endcase
   end
   assign output_pin_oe_n = (output_pin_mode == OMFS_PIN_TRISTATE);

   assign diagnostic_state = (state_ff == OMFS_ST_DIAG);
   assign command_state = (state_ff == OMFS_ST_COMMAND);
   assign normal_run_state = (state_ff == OMFS_ST_NORMAL);
   assign owi_window_open = win_open;

   // One-wire readout
   logic rd_prev_ff, rd_edge, rd_allowed;
   assign rd_edge = rd_req_s && !rd_prev_ff;
   assign rd_allowed = (mode_ff != OMFS_ANALOG) || command_state;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_prev_ff <= 1'b0;
         owi_read_ack <= 1'b0;
         owi_read_refused <= 1'b0;
         owi_read_data <= '0;
      end else begin
         rd_prev_ff <= rd_req_s;
         owi_read_ack <= rd_edge && rd_allowed;
         owi_read_refused <= rd_edge && !rd_allowed;
         if (rd_edge && rd_allowed) begin
            owi_read_data <= diagnostic_state ? `OMFS_ERR_CODE : result;
         end
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   assign ev = {state_ff == OMFS_ST_WINDOW && nxt_state == OMFS_ST_NORMAL, cmd_take,
                open_s || short_s, par_s || reg_par_err, mem_s, osc_fail, wdog_fail};
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~((reg_wr && reg_addr == `OMFS_REG_IRQ_STAT)
                        ? reg_wdata[`OMFS_EV_W-1:0] : '0)) | ev;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_ff <= '0;
         ctrl_ff <= `OMFS_CTRL_RST;
      end else if (reg_wr) begin
         if (reg_addr == `OMFS_REG_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata[`OMFS_EV_W-1:0];
         end
         if (reg_addr == `OMFS_REG_CTRL) begin
            ctrl_ff <= reg_wdata;
         end
      end
   end
   // Parity bits kept beside the control registers; a later flip of any
   // stored bit shows as a mismatch and is handled like any failure
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_par_ff <= ^`OMFS_CTRL_RST;
         mask_par_ff <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == `OMFS_REG_IRQ_MASK) begin
            mask_par_ff <= word_parity({9'h000, reg_wdata[`OMFS_EV_W-1:0]});
         end
         if (reg_addr == `OMFS_REG_CTRL) begin
            ctrl_par_ff <= word_parity(reg_wdata);
         end
      end
   end
   assign reg_par_err = (ctrl_par_ff != word_parity(ctrl_ff))
                        || (mask_par_ff != word_parity({9'h000, irq_mask_ff}));

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // Register readback, one cycle after the read strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `OMFS_REG_CTRL: reg_rdata <= ctrl_ff;
            `OMFS_REG_STATUS: reg_rdata <= {8'h00, mode_ff, output_pin_mode,
                                            1'b0, state_ff};
            `OMFS_REG_IRQ_STAT: reg_rdata <= {8'h00, 1'b0, irq_stat_ff};
            `OMFS_REG_IRQ_MASK: reg_rdata <= {8'h00, 1'b0, irq_mask_ff};
            `OMFS_REG_RESULT: begin
               reg_rdata <= diagnostic_state ? `OMFS_ERR_CODE
                                             : (result_valid ? result : 16'h0000);
            end
            `OMFS_REG_ERRCODE: reg_rdata <= `OMFS_ERR_CODE;
            `OMFS_REG_WINCNT: reg_rdata <= win_cnt_ff[15:0];
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule

/* hw/omfs_consts.svh */
`ifndef OMFS_CONSTS_SVH
`define OMFS_CONSTS_SVH

// Register map (word offsets, byte address = offset)
`define OMFS_REG_CTRL      4'h0
`define OMFS_REG_STATUS    4'h1
`define OMFS_REG_IRQ_STAT  4'h2
`define OMFS_REG_IRQ_MASK  4'h3
`define OMFS_REG_RESULT    4'h4
`define OMFS_REG_ERRCODE   4'h5
`define OMFS_REG_WINCNT    4'h6

// Control register fields
`define OMFS_CTRL_CLR_DIAG 0
`define OMFS_CTRL_RST      16'h0000

// Event bit positions
`define OMFS_EV_WDOG       0
`define OMFS_EV_OSC        1
`define OMFS_EV_MEM        2
`define OMFS_EV_PARITY     3
`define OMFS_EV_SENSOR     4
`define OMFS_EV_CMD        5
`define OMFS_EV_WIN_END    6
`define OMFS_EV_W          7

// Error code returned for readouts in diagnostic state
`define OMFS_ERR_CODE      16'hffff

// Mode encodings of the two-bit configuration field
`define OMFS_MODE_OWI_ONLY 2'h0
`define OMFS_MODE_WINDOW   2'h1
`define OMFS_MODE_OVERDRV  2'h2
`define OMFS_MODE_ANALOG   2'h3

// Window: 500 ms measured in internal oscillator cycles at 3 MHz
`define OMFS_WIN_MS        500
`define OMFS_OSC_KHZ       3000
`define OMFS_WIN_CYCLES    (`OMFS_WIN_MS * `OMFS_OSC_KHZ)

// Watchdog: system clock cycles without a kick
`define OMFS_WDOG_CYCLES   20'h186a0
// Oscillator monitor: longest gap between oscillator ticks in ref_clk cycles
`define OMFS_OSC_GAP       8'h40
// Measurement-start: number of conversions
`define OMFS_START_CONV    3'h5

`endif

/* hw/omfs_pkg.sv */
package omfs_pkg;
   typedef enum logic [1:0] {
      OMFS_OWI_ONLY,
      OMFS_WINDOW,
      OMFS_OVERDRV,
      OMFS_ANALOG
   } omfs_mode_t;

   typedef enum logic [1:0] {
      OMFS_PIN_TRISTATE,
      OMFS_PIN_FAULT_BAND,
      OMFS_PIN_ANALOG
   } omfs_pin_t;
endpackage

/* hw/omfs_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of asynchronous levels
module omfs_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

/* verif/omfs_ctrl_sva.sv */
`timescale 1ns/1ps
module omfs_ctrl_chk
   import omfs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Failure sources
   input wire logic mem_check_fail,
   input wire logic reg_parity_fail,
   input wire logic sensor_open,
   input wire logic sensor_short,
   // One-wire side
   input wire logic owi_read_ack,
   input wire logic owi_read_refused,
   input wire logic [15:0] owi_read_data,
   // Pin and states
   input wire omfs_pin_t output_pin_mode,
   input wire logic output_pin_oe_n,
   input wire logic diagnostic_state,
   input wire logic command_state,
   input wire logic normal_run_state,
   input wire logic owi_window_open,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Failure seen through the synchroniser reaches the diagnostic state
   sequence s_react;
      ##[1:4] diagnostic_state;
   endsequence
   AST_DIAG_PIN: assert property (diagnostic_state |->
      output_pin_mode == OMFS_PIN_FAULT_BAND && !output_pin_oe_n) else $error("diag pin");
   AST_MEM_FAIL: assert property (mem_check_fail && normal_run_state |-> s_react)
      else $error("mem fail ignored");
   AST_PAR_FAIL: assert property (reg_parity_fail && normal_run_state |-> s_react)
      else $error("parity fail ignored");
   AST_SENS_FAIL: assert property ((sensor_open || sensor_short) && normal_run_state
      |-> s_react) else $error("sensor fail ignored");
   AST_CMD_WIN: assert property ($rose(command_state) |-> $past(owi_window_open))
      else $error("command outside window");
   AST_ACK_EXCL: assert property (!(owi_read_ack && owi_read_refused))
      else $error("ack and refuse together");
   AST_OWI_ERR: assert property ($past(diagnostic_state) && owi_read_ack
      |-> owi_read_data == 16'hffff) else $error("owi data in diag");
   AST_ERRCODE: assert property ($past(reg_rd) && $past(reg_addr) == 4'h5
      |-> reg_rdata == 16'hffff) else $error("error code");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("rdata not idle");
   AST_DIAG_EXIT: assert property ($fell(diagnostic_state) |->
      ($past(reg_wr) && $past(reg_addr) == 4'h0)
      || ($past(reg_wr, 2) && $past(reg_addr, 2) == 4'h0))
      else $error("diag left without clear");
endmodule

/* verif/omfs_owi_master.sv */
`timescale 1ns/1ps
module omfs_owi_master (
   // Clock, reset and triggers
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic do_cmd,
   input wire logic do_read,
   // Answers from the block
   input wire logic owi_read_ack,
   input wire logic owi_read_refused,
   // Link requests
   output logic enter_command_request,
   output logic owi_read_req
);
   logic [2:0] cmd_ff;
   // Command held past the synchroniser, overriding the driven pin level
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) cmd_ff <= 3'h0;
      else if (do_cmd) cmd_ff <= 3'h6;
      else if (cmd_ff != 3'h0) cmd_ff <= cmd_ff - 3'h1;
   end
   assign enter_command_request = (cmd_ff != 3'h0);
   // Read request held until the block answers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) owi_read_req <= 1'b0;
      else if (do_read) owi_read_req <= 1'b1;
      else if (owi_read_ack || owi_read_refused) owi_read_req <= 1'b0;
   end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import omfs_pkg::*;
   logic ref_clk, rstn, cfg_loaded, conv_done, osc_tick, wdog_kick, mem_check_fail;
   logic reg_parity_fail, sensor_open, sensor_short, result_valid, reg_wr, reg_rd;
   logic do_cmd, do_read, enter_command_request, owi_read_req, owi_read_ack;
   logic owi_read_refused, output_pin_oe_n, diagnostic_state, command_state;
   logic normal_run_state, owi_window_open, irq, kick_run, osc_run;
   logic [1:0] cfg_mode;
   logic [3:0] reg_addr;
   logic [15:0] result, reg_wdata, reg_rdata, owi_read_data;
   omfs_pin_t output_pin_mode;
   int n_errors, n_checks, k;
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      osc_tick = 0;
      #5;
      forever #50 if (osc_run) osc_tick = ~osc_tick;
   end
   always @(posedge ref_clk) wdog_kick <= kick_run && rstn && !wdog_kick;
   omfs_ctrl #(.WIN_CYCLES(20), .WDOG_CYCLES(400)) DUT (.ref_clk, .rstn, .cfg_loaded,
      .cfg_mode, .conv_done, .osc_tick, .wdog_kick, .mem_check_fail, .reg_parity_fail,
      .sensor_open, .sensor_short, .result, .result_valid, .enter_command_request,
      .owi_read_req, .owi_read_ack, .owi_read_refused, .owi_read_data, .output_pin_mode,
      .output_pin_oe_n, .diagnostic_state, .command_state, .normal_run_state,
      .owi_window_open, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
   omfs_owi_master master (.ref_clk, .rstn, .do_cmd, .do_read, .owi_read_ack,
      .owi_read_refused, .enter_command_request, .owi_read_req);
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, e);
   endtask
   task conv(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         conv_done <= 1'b1;
         @(posedge ref_clk);
         conv_done <= 1'b0;
      end
   endtask
   task boot(input logic [1:0] m);
      @(posedge ref_clk);
      rstn <= 1'b0;
      cfg_loaded <= 1'b0;
      {mem_check_fail, reg_parity_fail, sensor_open, sensor_short} <= 4'h0;
      kick_run <= 1'b1;
      osc_run <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      cfg_mode <= m;
      repeat (2) @(posedge ref_clk);
      cfg_loaded <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask
   task wait_st(input logic diag);
      k = 0;
      while (k < 800 && (diag ? diagnostic_state : normal_run_state) !== 1'b1) begin
         @(negedge ref_clk);
         k++;
      end
      if (k == 800) n_errors++;
   endtask
   task owi_rd(input logic [1:0] e, input logic [15:0] d);
      @(posedge ref_clk);
      do_read <= 1'b1;
      @(posedge ref_clk);
      do_read <= 1'b0;
      k = 0;
      while (k < 20 && owi_read_ack !== 1'b1 && owi_read_refused !== 1'b1) begin
         @(negedge ref_clk);
         k++;
      end
      chk(16'({owi_read_ack, owi_read_refused}), 16'(e));
      if (e == 2'h2) chk(owi_read_data, d);
   endtask
   initial begin
      {rstn, cfg_loaded, cfg_mode, conv_done, reg_wr, reg_rd} = '0;
      {mem_check_fail, reg_parity_fail, sensor_open, sensor_short, do_cmd, do_read} = '0;
      {reg_addr, reg_wdata, n_errors, n_checks} = '0;
      {kick_run, osc_run, result_valid} = 3'h7;
      result = 16'h1234;
      for (int m = 0; m < 4; m++) begin
         boot(m[1:0]);
         @(negedge ref_clk);
         chk(16'(output_pin_mode), 16'(m >= 2 ? OMFS_PIN_FAULT_BAND : OMFS_PIN_TRISTATE));
         wr(4'h3, 16'h0040);
         conv(5);
         @(negedge ref_clk);
         chk(16'(owi_window_open), 16'(m == 1 || m == 2));
         if (m == 2) chk(16'(output_pin_mode), 16'(OMFS_PIN_ANALOG));
         wait_st(1'b0);
         chk(16'(output_pin_mode), 16'(m == 0 ? OMFS_PIN_TRISTATE : OMFS_PIN_ANALOG));
         chk(16'(irq), 16'(m == 1 || m == 2));
         wr(4'h2, 16'h0040);
         @(negedge ref_clk);
         chk(16'(irq), 16'h0000);
         owi_rd(m == 3 ? 2'h1 : 2'h2, 16'h1234);
         rd(4'h4, 16'h1234);
      end
      for (int c = 0; c < 2; c++) begin
         boot(c ? 2'h1 : 2'h2);
         conv(5);
         if (c) wait_st(1'b0);
         @(posedge ref_clk);
         do_cmd <= 1'b1;
         @(posedge ref_clk);
         do_cmd <= 1'b0;
         repeat (10) @(negedge ref_clk);
         chk(16'(command_state), 16'(c == 0));
      end
      for (int f = 0; f < 7; f++) begin
         boot(2'h0);
         if (f < 6) conv(5);
         if (f < 6) wait_st(1'b0);
         @(posedge ref_clk);
         case (f)
            0: kick_run <= 1'b0;
            1: osc_run <= 1'b0;
            3: reg_parity_fail <= 1'b1;
            4: sensor_open <= 1'b1;
            5: sensor_short <= 1'b1;
            default: mem_check_fail <= 1'b1;
         endcase
         wait_st(1'b1);
         chk(16'(diagnostic_state), 16'h0001);
         chk(16'({output_pin_oe_n, output_pin_mode}), 16'({1'b0, OMFS_PIN_FAULT_BAND}));
         rd(4'h5, 16'hffff);
         rd(4'h4, 16'hffff);
         owi_rd(2'h2, 16'hffff);
         rd(4'h1, 16'h0015);
         rd(4'h2, 16'h0001 << (f == 6 ? 2 : (f == 5 ? 4 : f)));
         chk(16'(irq), 16'h0000);
         wr(4'h3, 16'h001f);
         @(negedge ref_clk);
         chk(16'(irq), 16'h0001);
         rd(4'h3, 16'h001f);
      end
      @(posedge ref_clk);
      mem_check_fail <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(4'h0, 16'h0001);
      repeat (3) @(negedge ref_clk);
      chk(16'(diagnostic_state), 16'h0000);
      rd(4'h0, 16'h0001);
      rd(4'hf, 16'h0000);
      conclude;
   end
   initial begin
      #200000;
      n_errors++;
      conclude;
   end
endmodule
bind omfs_ctrl omfs_ctrl_chk chk (.ref_clk, .rstn, .mem_check_fail, .reg_parity_fail,
   .sensor_open, .sensor_short, .owi_read_ack, .owi_read_refused, .owi_read_data,
   .output_pin_mode, .output_pin_oe_n, .diagnostic_state, .command_state, .normal_run_state,
   .owi_window_open, .reg_addr, .reg_wr, .reg_rd, .reg_rdata);
